//--- include/status_out_pkg.sv
// Constants, register map and types for the servo status output block
`default_nettype none
package status_out_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned ZERO_PULSE_US = 400;
    localparam int unsigned ZERO_PULSE_CYCLES = ZERO_PULSE_US * CLK_MHZ;
    localparam int unsigned WARN_SETTLE_MS = 1500;
    localparam int unsigned WARN_SETTLE_CYCLES = WARN_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int unsigned ZERO_CNT_W = 24;
    localparam int unsigned SETTLE_CNT_W = 32;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_OUT_ASSIGN = 8'h00;
    localparam logic [7:0] OFS_ZS_THRESH = 8'h04;
    localparam logic [7:0] OFS_PULSE_COUNT = 8'h08;
    localparam logic [7:0] OFS_PULSE_DIR = 8'h0C;
    localparam logic [7:0] OFS_MON_SEL_FIRST = 8'h10;
    localparam logic [7:0] OFS_MON_SEL_SECOND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int unsigned PIN_COUNT = 3;
    localparam int unsigned FUNC_W = 3;
    localparam int unsigned ASSIGN_W = PIN_COUNT * FUNC_W;
    localparam int unsigned MON_SEL_W = 2;
    localparam int unsigned MON_W = 10;
    localparam int unsigned STATUS_W = 7;
    localparam logic [ASSIGN_W-1:0] RST_OUT_ASSIGN = 9'h000;
    localparam logic [15:0] RST_ZS_THRESH = 16'h0032;
    localparam logic [15:0] ZS_HYSTERESIS = 16'h0014;
    localparam logic [15:0] RST_PULSE_COUNT = 16'h0FA0;
    localparam logic RST_PULSE_DIR = 1'b0;
    localparam logic [MON_SEL_W-1:0] RST_MON_SEL_FIRST = 2'h0;
    localparam logic [MON_SEL_W-1:0] RST_MON_SEL_SECOND = 2'h1;
    // ****************************************
    // Encoder resolution and warning codes
    // ****************************************
    localparam int unsigned ENC_RES_W = 18;
    localparam logic [ENC_RES_W:0] ENC_RES = 19'h40000;
    localparam logic [7:0] CODE_BATT_CABLE = 8'h92;
    localparam logic [7:0] CODE_BATT_LOW = 8'h9F;
    // ****************************************
    // Output function codes
    // ****************************************
    typedef enum logic [FUNC_W-1:0] {
        FN_NONE = 3'h0,
        FN_TORQUE_LIMIT = 3'h1,
        FN_ZERO_SPEED = 3'h2,
        FN_WARNING = 3'h3,
        FN_BATTERY = 3'h4,
        FN_GAIN_SWITCH = 3'h5,
        FN_POS_LOST = 3'h6
    } out_func_type;
endpackage : status_out_pkg
`default_nettype wire

//--- include/pulse_gen_if.sv
// Interface between status logic and the encoder pulse generator
`default_nettype none
interface pulse_gen_if;
    logic step;
    logic step_ccw;
    logic zero_mark;
    logic [15:0] pulse_count;
    logic dir_invert;
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic z;
    logic z_n;
    modport gen (
        input step, step_ccw, zero_mark, pulse_count, dir_invert,
        output a, a_n, b, b_n, z, z_n
    );
    modport ctl (
        output step, step_ccw, zero_mark, pulse_count, dir_invert,
        input a, a_n, b, b_n, z, z_n
    );
endinterface : pulse_gen_if
`default_nettype wire

//--- logic/monitor_select.sv
// Analog monitor source selection with registered 10-bit code
`default_nettype none
module monitor_select (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection and sources
    input wire logic [status_out_pkg::MON_SEL_W-1:0] sel,
    input wire logic [15:0] src_speed,
    input wire logic [15:0] src_torque,
    input wire logic [15:0] src_limit,
    input wire logic [15:0] src_pos_error,
    // Code out
    output logic [status_out_pkg::MON_W-1:0] code_q
);
    logic [15:0] chosen;
    logic [status_out_pkg::MON_W-1:0] code_d;

    // Signed source to offset binary, top ten bits
    assign chosen = (sel == 2'h0) ? src_speed :
                    (sel == 2'h1) ? src_torque :
                    (sel == 2'h2) ? src_limit : src_pos_error;
    assign code_d = {~chosen[15], chosen[14:6]};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            code_q <= 10'h000;
        else
            code_q <= code_d;
    end
endmodule : monitor_select
`default_nettype wire

//--- logic/quad_encoder_out.sv
// Divided A/B quadrature output and stretched zero-point pulse
`default_nettype none
module quad_encoder_out #(
    parameter int unsigned ZERO_PULSE_CYCLES = status_out_pkg::ZERO_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Generator side
    pulse_gen_if.gen pg
);
    localparam int unsigned RW = status_out_pkg::ENC_RES_W;
    localparam int unsigned CW = status_out_pkg::ZERO_CNT_W;
    localparam logic [CW-1:0] ZLOAD = CW'(ZERO_PULSE_CYCLES - 1);

    logic [RW-1:0] acc_q;
    logic [RW-1:0] acc_d;
    logic [RW:0] sum;
    logic edge_due;
    logic forward;
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic [CW-1:0] zcnt_q;
    logic [CW-1:0] zcnt_d;
    logic z_d;

    // ****************************************
    // Divider: pulse_count A/B periods per revolution
    // ****************************************
    assign sum = {1'b0, acc_q} + {1'b0, pg.pulse_count, 2'b00};
    assign edge_due = pg.step && (sum >= status_out_pkg::ENC_RES);
    assign acc_d = !pg.step ? acc_q :
                   edge_due ? RW'(sum - status_out_pkg::ENC_RES) : sum[RW-1:0];
    assign forward = pg.step_ccw ^ pg.dir_invert;
    assign phase_d = !edge_due ? phase_q : forward ? phase_q + 2'h1 : phase_q - 2'h1;

    // ****************************************
    // Zero-point stretch
    // ****************************************
    assign zcnt_d = pg.zero_mark ? ZLOAD : (zcnt_q != '0) ? zcnt_q - CW'(1) : zcnt_q;
    assign z_d = pg.zero_mark || (zcnt_q != '0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= '0;
            phase_q <= 2'h0;
            zcnt_q <= '0;
            pg.a <= 1'b0;
            pg.a_n <= 1'b1;
            pg.b <= 1'b0;
            pg.b_n <= 1'b1;
            pg.z <= 1'b0;
            pg.z_n <= 1'b1;
        end
        else
        begin
            acc_q <= acc_d;
            phase_q <= phase_d;
            zcnt_q <= zcnt_d;
            // Forward walk A leads B by a quarter period
            pg.a <= phase_d[0] ^ phase_d[1];
            pg.a_n <= ~(phase_d[0] ^ phase_d[1]);
            pg.b <= phase_d[1];
            pg.b_n <= ~phase_d[1];
            pg.z <= z_d;
            pg.z_n <= ~z_d;
        end
    end
endmodule : quad_encoder_out
`default_nettype wire

//--- logic/servo_status_output_logic.sv
// Servo status outputs, encoder pulse outputs and analog monitors with Wishbone registers
`default_nettype none
module servo_status_output_logic #(
    parameter int unsigned ZERO_PULSE_CYCLES = status_out_pkg::ZERO_PULSE_CYCLES,
    parameter int unsigned WARN_SETTLE_CYCLES = status_out_pkg::WARN_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Servo control core
    input wire logic SERVO_ON,
    input wire logic [15:0] MOTOR_SPEED,
    input wire logic [15:0] TORQUE,
    input wire logic [15:0] TORQUE_LIMIT,
    input wire logic WARNING_ACTIVE,
    input wire logic [7:0] WARNING_CODE,
    input wire logic VAR_GAIN_ACTIVE,
    input wire logic ABS_POS_ERASED,
    input wire logic POSITION_LOOP_MODE,
    input wire logic [15:0] POS_ERROR,
    // Encoder position events
    input wire logic ENC_STEP,
    input wire logic ENC_STEP_CCW,
    input wire logic ENC_ZERO_MARK,
    // Discrete status pins
    output logic [status_out_pkg::PIN_COUNT-1:0] STATUS_PIN,
    // Encoder pulse outputs
    output logic ENC_OUT_A,
    output logic ENC_OUT_A_N,
    output logic ENC_OUT_B,
    output logic ENC_OUT_B_N,
    output logic ENC_OUT_ZERO,
    output logic ENC_OUT_ZERO_N,
    // Analog monitor codes
    output logic [status_out_pkg::MON_W-1:0] ANALOG_MONITOR_FIRST,
    output logic [status_out_pkg::MON_W-1:0] ANALOG_MONITOR_SECOND
);
    localparam int unsigned SW = status_out_pkg::SETTLE_CNT_W;
    localparam logic [SW-1:0] SETTLE_LAST = SW'(WARN_SETTLE_CYCLES - 1);

    // ****************************************
    // Byte-lane write merge
    // ****************************************
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction : merge_lanes

    // ****************************************
    // Registers
    // ****************************************
    logic [status_out_pkg::ASSIGN_W-1:0] assign_q;
    logic [15:0] zs_thresh_q;
    logic [15:0] pulse_count_q;
    logic pulse_dir_q;
    logic [status_out_pkg::MON_SEL_W-1:0] mon_sel_first_q;
    logic [status_out_pkg::MON_SEL_W-1:0] mon_sel_second_q;

    logic ack_q;
    logic [31:0] rdata_q;

    logic [status_out_pkg::ASSIGN_W-1:0] assign_d;
    logic [15:0] zs_thresh_d;
    logic [15:0] pulse_count_d;
    logic pulse_dir_d;
    logic [status_out_pkg::MON_SEL_W-1:0] mon_sel_first_d;
    logic [status_out_pkg::MON_SEL_W-1:0] mon_sel_second_d;

    logic ack_d;
    logic [31:0] rdata_d;

    // ****************************************
    // Status state
    // ****************************************
    logic torque_limit_reached_q;
    logic zero_speed_flag_q;
    logic warning_flag_q;
    logic battery_warning_flag_q;
    logic gain_switch_active_q;
    logic position_lost_flag_q;

    logic settled_q;
    logic [SW-1:0] settle_cnt_q;

    logic [status_out_pkg::PIN_COUNT-1:0] pin_q;

    logic torque_limit_reached_d;
    logic zero_speed_flag_d;
    logic warning_flag_d;
    logic battery_warning_flag_d;
    logic gain_switch_active_d;
    logic position_lost_flag_d;

    logic settled_d;
    logic [SW-1:0] settle_cnt_d;

    logic [status_out_pkg::PIN_COUNT-1:0] pin_d;

    // ****************************************
    // Bus decode
    // ****************************************
    wire req = WB_CYC_I && WB_STB_I && !ack_q;
    wire wr = req && WB_WE_I;

    wire hit_assign = WB_ADR_I == status_out_pkg::OFS_OUT_ASSIGN;
    wire hit_thresh = WB_ADR_I == status_out_pkg::OFS_ZS_THRESH;
    wire hit_count = WB_ADR_I == status_out_pkg::OFS_PULSE_COUNT;
    wire hit_dir = WB_ADR_I == status_out_pkg::OFS_PULSE_DIR;
    wire hit_mon1 = WB_ADR_I == status_out_pkg::OFS_MON_SEL_FIRST;
    wire hit_mon2 = WB_ADR_I == status_out_pkg::OFS_MON_SEL_SECOND;
    wire hit_status = WB_ADR_I == status_out_pkg::OFS_STATUS;

    wire [31:0] wv_assign = merge_lanes(32'(assign_q), WB_DAT_I, WB_SEL_I);
    wire [31:0] wv_thresh = merge_lanes(32'(zs_thresh_q), WB_DAT_I, WB_SEL_I);
    wire [31:0] wv_count = merge_lanes(32'(pulse_count_q), WB_DAT_I, WB_SEL_I);
    wire [31:0] wv_dir = merge_lanes(32'(pulse_dir_q), WB_DAT_I, WB_SEL_I);
    wire [31:0] wv_mon1 = merge_lanes(32'(mon_sel_first_q), WB_DAT_I, WB_SEL_I);
    wire [31:0] wv_mon2 = merge_lanes(32'(mon_sel_second_q), WB_DAT_I, WB_SEL_I);

    assign assign_d = (wr && hit_assign) ? wv_assign[status_out_pkg::ASSIGN_W-1:0] : assign_q;
    assign zs_thresh_d = (wr && hit_thresh) ? wv_thresh[15:0] : zs_thresh_q;
    assign pulse_count_d = (wr && hit_count) ? wv_count[15:0] : pulse_count_q;
    assign pulse_dir_d = (wr && hit_dir) ? wv_dir[0] : pulse_dir_q;
    assign mon_sel_first_d = (wr && hit_mon1) ? wv_mon1[status_out_pkg::MON_SEL_W-1:0] : mon_sel_first_q;
    assign mon_sel_second_d = (wr && hit_mon2) ? wv_mon2[status_out_pkg::MON_SEL_W-1:0] : mon_sel_second_q;

    wire [status_out_pkg::STATUS_W-1:0] status_word = {settled_q, position_lost_flag_q, gain_switch_active_q,
        battery_warning_flag_q, warning_flag_q, zero_speed_flag_q, torque_limit_reached_q};

    // Unmapped offsets read zero, writes to them are dropped
    assign rdata_d = !req ? 32'h00000000 :
                     hit_assign ? 32'(assign_q) :
                     hit_thresh ? 32'(zs_thresh_q) :
                     hit_count ? 32'(pulse_count_q) :
                     hit_dir ? 32'(pulse_dir_q) :
                     hit_mon1 ? 32'(mon_sel_first_q) :
                     hit_mon2 ? 32'(mon_sel_second_q) :
                     hit_status ? 32'(status_word) : 32'h00000000;
    assign ack_d = req;

    // ****************************************
    // Speed and torque magnitudes
    // ****************************************
    wire [15:0] speed_abs = MOTOR_SPEED[15] ? 16'(-MOTOR_SPEED) : MOTOR_SPEED;
    wire [15:0] torque_abs = TORQUE[15] ? 16'(-TORQUE) : TORQUE;
    wire [16:0] zs_off_level = {1'b0, zs_thresh_q} + {1'b0, status_out_pkg::ZS_HYSTERESIS};

    // ****************************************
    // Status functions
    // ****************************************
    assign torque_limit_reached_d = SERVO_ON && (torque_abs >= TORQUE_LIMIT);
    assign zero_speed_flag_d = zero_speed_flag_q ? ({1'b0, speed_abs} < zs_off_level)
                                                 : (speed_abs <= zs_thresh_q);

    // Power-on settle window for the warning outputs
    assign settle_cnt_d = settled_q ? settle_cnt_q : settle_cnt_q + SW'(1);
    assign settled_d = settled_q || (settle_cnt_q == SETTLE_LAST);

    wire batt_code = (WARNING_CODE == status_out_pkg::CODE_BATT_CABLE)
                     || (WARNING_CODE == status_out_pkg::CODE_BATT_LOW);
    assign warning_flag_d = settled_q && WARNING_ACTIVE;
    assign battery_warning_flag_d = settled_q && WARNING_ACTIVE && batt_code;
    assign gain_switch_active_d = VAR_GAIN_ACTIVE;
    assign position_lost_flag_d = ABS_POS_ERASED && !POSITION_LOOP_MODE;

    // ****************************************
    // Pin assignment
    // ****************************************
    logic [6:0] func_vec;
    assign func_vec = {position_lost_flag_q, gain_switch_active_q, battery_warning_flag_q,
                       warning_flag_q, zero_speed_flag_q, torque_limit_reached_q, 1'b0};

    genvar gp;
    generate
        for (gp = 0; gp < status_out_pkg::PIN_COUNT; gp++)
        begin : g_pin
            wire [status_out_pkg::FUNC_W-1:0] fsel = assign_q[gp*status_out_pkg::FUNC_W +: status_out_pkg::FUNC_W];
            // FN_NONE and unused codes drive the pin inactive
            assign pin_d[gp] = (fsel != status_out_pkg::FN_NONE) && (fsel <= status_out_pkg::FN_POS_LOST)
                               && func_vec[fsel];
        end
    endgenerate

    // ****************************************
    // Clocked state
    // ****************************************
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            assign_q <= status_out_pkg::RST_OUT_ASSIGN;
            zs_thresh_q <= status_out_pkg::RST_ZS_THRESH;
            pulse_count_q <= status_out_pkg::RST_PULSE_COUNT;
            pulse_dir_q <= status_out_pkg::RST_PULSE_DIR;
            mon_sel_first_q <= status_out_pkg::RST_MON_SEL_FIRST;
            mon_sel_second_q <= status_out_pkg::RST_MON_SEL_SECOND;

            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            assign_q <= assign_d;
            zs_thresh_q <= zs_thresh_d;
            pulse_count_q <= pulse_count_d;
            pulse_dir_q <= pulse_dir_d;
            mon_sel_first_q <= mon_sel_first_d;
            mon_sel_second_q <= mon_sel_second_d;

            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            torque_limit_reached_q <= 1'b0;
            zero_speed_flag_q <= 1'b0;
            warning_flag_q <= 1'b0;
            battery_warning_flag_q <= 1'b0;
            gain_switch_active_q <= 1'b0;
            position_lost_flag_q <= 1'b0;

            settled_q <= 1'b0;
            settle_cnt_q <= '0;

            pin_q <= '0;
        end
        else
        begin
            torque_limit_reached_q <= torque_limit_reached_d;
            zero_speed_flag_q <= zero_speed_flag_d;
            warning_flag_q <= warning_flag_d;
            battery_warning_flag_q <= battery_warning_flag_d;
            gain_switch_active_q <= gain_switch_active_d;
            position_lost_flag_q <= position_lost_flag_d;

            settled_q <= settled_d;
            settle_cnt_q <= settle_cnt_d;

            pin_q <= pin_d;
        end
    end

    // ****************************************
    // Encoder pulse generator
    // ****************************************
    pulse_gen_if pg ();
    assign pg.step = ENC_STEP;
    assign pg.step_ccw = ENC_STEP_CCW;
    assign pg.zero_mark = ENC_ZERO_MARK;

    assign pg.pulse_count = pulse_count_q;
    assign pg.dir_invert = pulse_dir_q;

    quad_encoder_out #(
        .ZERO_PULSE_CYCLES(ZERO_PULSE_CYCLES)
    ) u_quad (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .pg(pg.gen)
    );

    // ****************************************
    // Analog monitors
    // ****************************************
    monitor_select u_mon_first (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .sel(mon_sel_first_q),
        .src_speed(MOTOR_SPEED),
        .src_torque(TORQUE),
        .src_limit(TORQUE_LIMIT),
        .src_pos_error(POS_ERROR),
        .code_q(ANALOG_MONITOR_FIRST)
    );

    monitor_select u_mon_second (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .sel(mon_sel_second_q),
        .src_speed(MOTOR_SPEED),
        .src_torque(TORQUE),
        .src_limit(TORQUE_LIMIT),
        .src_pos_error(POS_ERROR),
        .code_q(ANALOG_MONITOR_SECOND)
    );

    // ****************************************
    // Output drive
    // ****************************************
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    assign STATUS_PIN = pin_q;

    assign ENC_OUT_A = pg.a;
    assign ENC_OUT_A_N = pg.a_n;
    assign ENC_OUT_B = pg.b;
    assign ENC_OUT_B_N = pg.b_n;
    assign ENC_OUT_ZERO = pg.z;
    assign ENC_OUT_ZERO_N = pg.z_n;
endmodule : servo_status_output_logic
`default_nettype wire

//--- testbench/servo_status_output_logic_assertions.sv
// Port-level assertions for the servo status output block
`default_nettype none
module status_out_checker (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Encoder side
    input wire logic ENC_STEP,
    input wire logic ENC_ZERO_MARK,
    input wire logic ENC_OUT_A,
    input wire logic ENC_OUT_A_N,
    input wire logic ENC_OUT_B,
    input wire logic ENC_OUT_B_N,
    input wire logic ENC_OUT_ZERO,
    input wire logic ENC_OUT_ZERO_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged");
    data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    ab_pair_a: assert property (ENC_OUT_A_N == !ENC_OUT_A && ENC_OUT_B_N == !ENC_OUT_B)
        else $error("A/B complement mismatch");
    z_pair_a: assert property (ENC_OUT_ZERO_N == !ENC_OUT_ZERO)
        else $error("zero complement mismatch");
    zero_start_a: assert property (ENC_ZERO_MARK |=> ENC_OUT_ZERO)
        else $error("zero pulse missing");
    zero_hold_a: assert property (ENC_ZERO_MARK |=> ENC_OUT_ZERO [*8])
        else $error("zero pulse too short");
    ab_still_a: assert property (!ENC_STEP |=> $stable({ENC_OUT_A, ENC_OUT_B}))
        else $error("A/B moved without a step");
    ab_gray_a: assert property (!($changed(ENC_OUT_A) && $changed(ENC_OUT_B)))
        else $error("A and B changed together");
    cover property (WB_ACK_O);
    cover property ($rose(ENC_OUT_ZERO));
    cover property ($rose(ENC_OUT_B));
endmodule : status_out_checker
bind servo_status_output_logic status_out_checker chk_i (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
    .WB_DAT_O, .WB_ACK_O, .ENC_STEP, .ENC_ZERO_MARK, .ENC_OUT_A, .ENC_OUT_A_N, .ENC_OUT_B,
    .ENC_OUT_B_N, .ENC_OUT_ZERO, .ENC_OUT_ZERO_N);
`default_nettype wire

//--- testbench/quad_receiver.sv
// Receiving equipment model: quadrature decoder and zero pulse width meter
`default_nettype none
module quad_receiver (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Encoder lines
    input wire logic a,
    input wire logic b,
    input wire logic z,
    // Decoded results
    output var int pos,
    output var int zw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pidx;
    int run;
    wire [1:0] idx = {b, a ^ b};
    wire [1:0] dlt = idx - pidx;
    always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
        pidx <= 2'h0;
        pos <= 0;
        run <= 0;
        zw <= 0;
    end
    else
    begin
        pidx <= idx;
        if (dlt == 2'h1)
            pos <= pos + 1;
        else if (dlt == 2'h3)
            pos <= pos - 1;
        run <= z ? run + 1 : 0;
        if (!z && run != 0)
            zw <= run;
    end
endmodule : quad_receiver
`default_nettype wire

//--- testbench/servo_status_output_logic_tb.sv
// Self-checking bench for the servo status output block
`default_nettype none
module servo_status_output_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 1'b0, RST_N = 1'b0, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, SERVO_ON;
    logic WARNING_ACTIVE, VAR_GAIN_ACTIVE, ABS_POS_ERASED, POSITION_LOOP_MODE;
    logic ENC_STEP, ENC_STEP_CCW, ENC_ZERO_MARK, ENC_OUT_A, ENC_OUT_A_N, ENC_OUT_B, ENC_OUT_B_N;
    logic ENC_OUT_ZERO, ENC_OUT_ZERO_N;
    logic [7:0] WB_ADR_I, WARNING_CODE;
    logic [3:0] WB_SEL_I, lanes = 4'hF;
    logic [31:0] WB_DAT_I, WB_DAT_O, seed = 32'h0000_15BD;
    logic [15:0] MOTOR_SPEED, TORQUE, TORQUE_LIMIT, POS_ERROR, src[4];
    logic [2:0] STATUS_PIN;
    logic [9:0] ANALOG_MONITOR_FIRST, ANALOG_MONITOR_SECOND;
    logic [31:0] expq[$];
    logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [31:0] rv[7] = '{32'h0, 32'h32, 32'hFA0, 32'h0, 32'h0, 32'h1, 32'h0};
    logic [15:0] sp[10] = '{16'h0, 16'h3C, 16'h46, 16'h32, 16'hFFBB, 16'hFFBA, 16'hFFCE, 16'h6E, 16'h78, 16'h64};
    logic ze[10] = '{1, 1, 0, 1, 1, 0, 1, 1, 0, 1};
    int fail_count = 0, n_compared = 0, pos, zw, cyc = 0;
    always #5 SYS_CLK = ~SYS_CLK;
    servo_status_output_logic #(.ZERO_PULSE_CYCLES(20), .WARN_SETTLE_CYCLES(50)) dut (.SYS_CLK, .RST_N,
        .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .SERVO_ON,
        .MOTOR_SPEED, .TORQUE, .TORQUE_LIMIT, .WARNING_ACTIVE, .WARNING_CODE, .VAR_GAIN_ACTIVE,
        .ABS_POS_ERASED, .POSITION_LOOP_MODE, .POS_ERROR, .ENC_STEP, .ENC_STEP_CCW, .ENC_ZERO_MARK,
        .STATUS_PIN, .ENC_OUT_A, .ENC_OUT_A_N, .ENC_OUT_B, .ENC_OUT_B_N, .ENC_OUT_ZERO, .ENC_OUT_ZERO_N,
        .ANALOG_MONITOR_FIRST, .ANALOG_MONITOR_SECOND);
    quad_receiver rx (.clk(SYS_CLK), .rst_n(RST_N), .a(ENC_OUT_A), .b(ENC_OUT_B), .z(ENC_OUT_ZERO),
        .pos(pos), .zw(zw));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] mon(input logic [15:0] s);
        return {22'h0, ~s[15], s[14:6]};
    endfunction : mon
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task stp(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : stp
    // Classic single cycle; a read pushes its expected data
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= lanes;
        if (!we)
            expq.push_back(d);
        do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1);
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge SYS_CLK);
    endtask : wb
    task io(input logic [7:0] c, input logic g, input logic ab, input logic lm);
        WARNING_CODE <= c;
        VAR_GAIN_ACTIVE <= g;
        ABS_POS_ERASED <= ab;
        POSITION_LOOP_MODE <= lm;
        stp(4);
    endtask : io
    always @(posedge SYS_CLK)
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0)
            chk("rdata", WB_DAT_O, expq.pop_front());
    always @(posedge SYS_CLK)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            fail_count++;
            end_sim();
        end
    end
    initial
    begin
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I, SERVO_ON, MOTOR_SPEED} = '0;
        {TORQUE, TORQUE_LIMIT, POS_ERROR, VAR_GAIN_ACTIVE, ABS_POS_ERASED, POSITION_LOOP_MODE} = '0;
        {ENC_STEP, ENC_STEP_CCW, ENC_ZERO_MARK} = '0;
        WARNING_ACTIVE = 1'b1;
        WARNING_CODE = 8'h92;
        stp(16);
        chk("rst", {STATUS_PIN, ENC_OUT_A_N, ENC_OUT_ZERO}, 32'h2);
        RST_N <= 1'b1;
        for (int i = 0; i < 7; i++)
            wb(1'b0, ofs[i], rv[i]);
        wb(1'b0, 8'h18, 32'h02);
        stp(40);
        wb(1'b0, 8'h18, 32'h4E);
        wb(1'b1, 8'h00, 32'h0D1);
        SERVO_ON <= 1'b1;
        TORQUE <= 16'd100;
        TORQUE_LIMIT <= 16'd100;
        stp(4);
        chk("pins", STATUS_PIN, 32'h7);
        SERVO_ON <= 1'b0;
        WARNING_ACTIVE <= 1'b0;
        stp(4);
        chk("pins", STATUS_PIN, 32'h2);
        for (int i = 0; i < 10; i++)
        begin
            lanes = (i == 7) ? 4'h1 : 4'hF;
            if (i == 7)
                wb(1'b1, 8'h04, 32'hFFFF_FF64);
            MOTOR_SPEED <= sp[i];
            stp(4);
            chk("zsp", STATUS_PIN[1], ze[i]);
        end
        wb(1'b1, 8'h00, 32'h1AC);
        WARNING_ACTIVE <= 1'b1;
        io(8'h92, 1'b0, 1'b1, 1'b0);
        chk("pins", STATUS_PIN, 32'h5);
        io(8'h9F, 1'b1, 1'b0, 1'b0);
        chk("pins", STATUS_PIN, 32'h3);
        io(8'h10, 1'b1, 1'b1, 1'b1);
        chk("pins", STATUS_PIN, 32'h2);
        io(8'h10, 1'b0, 1'b1, 1'b0);
        chk("pins", STATUS_PIN, 32'h4);
        wb(1'b1, 8'h00, 32'h1FF);
        stp(3);
        chk("pins", STATUS_PIN, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, 8'h10, 32'(k));
            wb(1'b1, 8'h14, 32'(3 - k));
            for (int j = 0; j < 4; j++)
                src[j] = rnd() >> 8;
            MOTOR_SPEED <= src[0];
            TORQUE <= src[1];
            TORQUE_LIMIT <= src[2];
            POS_ERROR <= src[3];
            stp(3);
            chk("mon1", ANALOG_MONITOR_FIRST, mon(src[k]));
            chk("mon2", ANALOG_MONITOR_SECOND, mon(src[3 - k]));
        end
        wb(1'b1, 8'h08, 32'd16384);
        ENC_STEP_CCW <= 1'b1;
        ENC_STEP <= 1'b1;
        stp(64);
        ENC_STEP <= 1'b0;
        stp(2);
        chk("pos", pos, 32'd16);
        wb(1'b1, 8'h0C, 32'h1);
        ENC_STEP <= 1'b1;
        stp(64);
        ENC_STEP <= 1'b0;
        stp(2);
        chk("pos", pos, 32'd0);
        ENC_ZERO_MARK <= 1'b1;
        stp(1);
        ENC_ZERO_MARK <= 1'b0;
        stp(30);
        chk("zwidth", zw, 32'd20);
        end_sim();
    end
endmodule : servo_status_output_logic_tb
`default_nettype wire
